// File: rtl/plser_map.vh
// constants for the 28-to-4 pixel serializer
`ifndef PLSER_MAP_VH
`define PLSER_MAP_VH

// timing
`define PLSER_CLK_PERIOD_NS 50
`define PLSER_LOCK_TIME_NS 10000
// settle time in clk cycles: 10 us at 50 ns a cycle
`define PLSER_LOCK_CYCLES 16'h00C8
`define PLSER_DIS_TIME_NS 12

// frame shape
`define PLSER_SLOTS 10'h007
`define PLSER_LAST_SLOT 3'h6
`define PLSER_CLK_HIGH_SLOTS 3'h4
`define PLSER_WORD_W 28
`define PLSER_LANES 4
`define PLSER_CNT_W 10
`define PLSER_CNT_MAX 10'h3FF

// parallel bit carried by each lane in each slot
`define PLSER_S0_L0 1
`define PLSER_S0_L1 9
`define PLSER_S0_L2 20
`define PLSER_S0_L3 5
`define PLSER_S1_L0 0
`define PLSER_S1_L1 8
`define PLSER_S1_L2 19
`define PLSER_S1_L3 27
`define PLSER_S2_L0 7
`define PLSER_S2_L1 18
`define PLSER_S2_L2 26
`define PLSER_S2_L3 23
`define PLSER_S3_L0 6
`define PLSER_S3_L1 15
`define PLSER_S3_L2 25
`define PLSER_S3_L3 17
`define PLSER_S4_L0 4
`define PLSER_S4_L1 14
`define PLSER_S4_L2 24
`define PLSER_S4_L3 16
`define PLSER_S5_L0 3
`define PLSER_S5_L1 13
`define PLSER_S5_L2 22
`define PLSER_S5_L3 11
`define PLSER_S6_L0 2
`define PLSER_S6_L1 12
`define PLSER_S6_L2 21
`define PLSER_S6_L3 10

`endif

// File: rtl/plser_fifo.v
// two-entry word buffer with valid and ready on both sides
`timescale 1ns/1ps
module plser_fifo #(
   parameter W = 28
) (
   clk,
   rst_n,
   in_valid,
   in_ready,
   in_data,
   out_valid,
   out_ready,
   out_data
);
   input wire clk;
   input wire rst_n;
   input wire in_valid;
   output wire in_ready;
   input wire [W-1:0] in_data;
   output wire out_valid;
   input wire out_ready;
   output wire [W-1:0] out_data;

   reg [W-1:0] mem0_r;
   reg [W-1:0] mem1_r;
   reg wr_ptr_r;
   reg rd_ptr_r;
   reg [1:0] count_r;
   wire push;
   wire pop;

   assign in_ready = (count_r != 2'h2);
   assign out_valid = (count_r != 2'h0);
   assign out_data = rd_ptr_r ? mem1_r : mem0_r;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mem0_r <= {W{1'b0}};
         mem1_r <= {W{1'b0}};
         wr_ptr_r <= 1'b0;
         rd_ptr_r <= 1'b0;
         count_r <= 2'h0;
      end else begin
         if (push && !wr_ptr_r)
            mem0_r <= in_data;
         if (push && wr_ptr_r)
            mem1_r <= in_data;
         if (push)
            wr_ptr_r <= ~wr_ptr_r;
         if (pop)
            rd_ptr_r <= ~rd_ptr_r;
         if (push && !pop)
            count_r <= count_r + 2'h1;
         else if (pop && !push)
            count_r <= count_r - 2'h1;
      end
   end
endmodule

// File: rtl/plser_top.v
// pixel serializer: 28 parallel bits onto four serial lanes plus clock
`timescale 1ns/1ps
`include "plser_map.vh"

// Overview of operation
// - slot 0 sends bits 1,9,20,5
// - slot 1 sends bits 0,8,19,27
// - slot 2 sends bits 7,18,26,23
// - slot 3 sends bits 6,15,25,17
// - slot 4 sends bits 4,14,24,16
// - slot 5 sends bits 3,13,22,11
// - slot 6 sends bits 2,12,21,10
// - slot k starts k/7 period after clock
// - forwarded clock high four sevenths period
// - lock and valid data 10 us after release
// - shutdown turns forwarded clock off quickly
// - sample edge chosen by edge select
// - shutdown stops clock, lanes, clears registers
// - high selects rising, low selects falling
module plser_top (
   clk,
   rst_n,
   pixel_clock_in,
   edge_select,
   shutdown_clear_n,
   parallel_pixel_bit,
   pixel_ready,
   serial_lane,
   serial_lane_oe,
   forwarded_clock_out,
   forwarded_clock_oe,
   lock_valid
);
   input wire clk;
   input wire rst_n;
   input wire pixel_clock_in;
   input wire edge_select;
   input wire shutdown_clear_n;
   input wire [`PLSER_WORD_W-1:0] parallel_pixel_bit;
   output reg pixel_ready;
   output reg [`PLSER_LANES-1:0] serial_lane;
   output reg serial_lane_oe;
   output reg forwarded_clock_out;
   output reg forwarded_clock_oe;
   output reg lock_valid;

   localparam [15:0] LOCK_CYC = `PLSER_LOCK_CYCLES;
   localparam [`PLSER_CNT_W-1:0] SLOT_STEP = `PLSER_SLOTS;

   // ******************************************************
   // reset and shutdown
   // ******************************************************
   // shutdown acts as an async clear so the drivers drop within one
   // gate delay, well inside the disable time; release is synchronised
   wire clr_n;
   reg rsync1_r;
   reg rsync2_r;
   wire irst_n;

   assign clr_n = rst_n & shutdown_clear_n;

   always @(posedge clk or negedge clr_n) begin
      if (!clr_n) begin
         rsync1_r <= 1'b0;
         rsync2_r <= 1'b0;
      end else begin
         rsync1_r <= 1'b1;
         rsync2_r <= rsync1_r;
      end
   end

   assign irst_n = rsync2_r & clr_n;

   // ******************************************************
   // input synchronisers
   // ******************************************************
   // data takes the same two stages as the clock, so the word seen at
   // a detected edge is the word that stood at that pin edge
   reg pclk1_r;
   reg pclk2_r;
   reg pclk3_r;
   reg esel1_r;
   reg esel2_r;
   reg [`PLSER_WORD_W-1:0] pdat1_r;
   reg [`PLSER_WORD_W-1:0] pdat2_r;

   always @(posedge clk or negedge irst_n) begin
      if (!irst_n) begin
         pclk1_r <= 1'b0;
         pclk2_r <= 1'b0;
         pclk3_r <= 1'b0;
         esel1_r <= 1'b0;
         esel2_r <= 1'b0;
         pdat1_r <= {`PLSER_WORD_W{1'b0}};
         pdat2_r <= {`PLSER_WORD_W{1'b0}};
      end else begin
         pclk1_r <= pixel_clock_in;
         pclk2_r <= pclk1_r;
         pclk3_r <= pclk2_r;
         esel1_r <= edge_select;
         esel2_r <= esel1_r;
         pdat1_r <= parallel_pixel_bit;
         pdat2_r <= pdat1_r;
      end
   end

   // edges are ignored until all three stages hold pin samples, else a
   // pin that is high at release would look like a fresh rising edge
   reg [1:0] fill_r;

   always @(posedge clk or negedge irst_n) begin
      if (!irst_n) begin
         fill_r <= 2'h0;
      end else if (fill_r != 2'h3) begin
         fill_r <= fill_r + 2'h1;
      end
   end

   wire rise_det;
   wire fall_det;
   wire frame_start;

   assign rise_det = (fill_r == 2'h3) & pclk2_r & ~pclk3_r;
   assign fall_det = (fill_r == 2'h3) & ~pclk2_r & pclk3_r;
   assign frame_start = esel2_r ? rise_det : fall_det;

   // ******************************************************
   // capture buffer
   // ******************************************************
   wire fifo_in_ready;
   wire fifo_out_valid;
   wire [`PLSER_WORD_W-1:0] fifo_out_data;

   plser_fifo #(
      .W(`PLSER_WORD_W)
   ) u_buf (
      .clk(clk),
      .rst_n(irst_n),
      .in_valid(frame_start),
      .in_ready(fifo_in_ready),
      .in_data(pdat2_r),
      .out_valid(fifo_out_valid),
      .out_ready(frame_start),
      .out_data(fifo_out_data)
   );

   // ******************************************************
   // period tracking and lock
   // ******************************************************
   // the bit clock is synthesised by a phase accumulator over the
   // measured pixel period; a period change shows one frame late
   reg [`PLSER_CNT_W-1:0] cnt_r;
   reg [`PLSER_CNT_W-1:0] period_r;
   reg [1:0] edges_r;
   reg [15:0] lock_cnt_r;
   reg live_r;
   wire measured;
   wire lock_due;
   wire locked;

   assign measured = (edges_r == 2'h2);
   assign lock_due = measured && (lock_cnt_r == LOCK_CYC);
   assign locked = live_r;

   always @(posedge clk or negedge irst_n) begin
      if (!irst_n) begin
         cnt_r <= {`PLSER_CNT_W{1'b0}};
         period_r <= {`PLSER_CNT_W{1'b0}};
         edges_r <= 2'h0;
         lock_cnt_r <= 16'h0000;
      end else begin
         if (frame_start) begin
            cnt_r <= {`PLSER_CNT_W{1'b0}};
            period_r <= cnt_r + 10'h001;
            if (!measured)
               edges_r <= edges_r + 2'h1;
         end else if (cnt_r != `PLSER_CNT_MAX) begin
            cnt_r <= cnt_r + 10'h001;
         end
         if (lock_cnt_r != LOCK_CYC)
            lock_cnt_r <= lock_cnt_r + 16'h0001;
      end
   end

   // outputs come alive only at a frame start, so the first frame that
   // leaves is whole and lanes and clock share its boundary
   always @(posedge clk or negedge irst_n) begin
      if (!irst_n) begin
         live_r <= 1'b0;
      end else if (frame_start && lock_due) begin
         live_r <= 1'b1;
      end
   end

   // ******************************************************
   // slot sequencer
   // ******************************************************
   // slots are whole clk cycles: with a short pixel period one slot in a
   // frame lasts a cycle longer, a limit of running the bit clock on clk
   reg [2:0] slot_r;
   reg [`PLSER_CNT_W-1:0] acc_r;
   reg [`PLSER_WORD_W-1:0] word_r;
   wire [`PLSER_CNT_W-1:0] acc_sum;

   assign acc_sum = acc_r + SLOT_STEP;

   always @(posedge clk or negedge irst_n) begin
      if (!irst_n) begin
         slot_r <= 3'h0;
         acc_r <= {`PLSER_CNT_W{1'b0}};
         word_r <= {`PLSER_WORD_W{1'b0}};
      end else begin
         if (frame_start) begin
            slot_r <= 3'h0;
            acc_r <= {`PLSER_CNT_W{1'b0}};
            if (fifo_out_valid)
               word_r <= fifo_out_data;
            else
               word_r <= {`PLSER_WORD_W{1'b0}};
         end else if (slot_r != `PLSER_LAST_SLOT) begin
            if (acc_sum >= period_r) begin
               slot_r <= slot_r + 3'h1;
               acc_r <= acc_sum - period_r;
            end else begin
               acc_r <= acc_sum;
            end
         end
      end
   end

   // ******************************************************
   // lane mapping
   // ******************************************************
   reg [`PLSER_LANES-1:0] lane_nxt;

   always @* begin
      case (slot_r)
         3'h0: begin
            lane_nxt = {word_r[`PLSER_S0_L3], word_r[`PLSER_S0_L2],
                        word_r[`PLSER_S0_L1], word_r[`PLSER_S0_L0]};
         end
         3'h1: begin
            lane_nxt = {word_r[`PLSER_S1_L3], word_r[`PLSER_S1_L2],
                        word_r[`PLSER_S1_L1], word_r[`PLSER_S1_L0]};
         end
         3'h2: begin
            lane_nxt = {word_r[`PLSER_S2_L3], word_r[`PLSER_S2_L2],
                        word_r[`PLSER_S2_L1], word_r[`PLSER_S2_L0]};
         end
         3'h3: begin
            lane_nxt = {word_r[`PLSER_S3_L3], word_r[`PLSER_S3_L2],
                        word_r[`PLSER_S3_L1], word_r[`PLSER_S3_L0]};
         end
         3'h4: begin
            lane_nxt = {word_r[`PLSER_S4_L3], word_r[`PLSER_S4_L2],
                        word_r[`PLSER_S4_L1], word_r[`PLSER_S4_L0]};
         end
         3'h5: begin
            lane_nxt = {word_r[`PLSER_S5_L3], word_r[`PLSER_S5_L2],
                        word_r[`PLSER_S5_L1], word_r[`PLSER_S5_L0]};
         end
         3'h6: begin
            lane_nxt = {word_r[`PLSER_S6_L3], word_r[`PLSER_S6_L2],
                        word_r[`PLSER_S6_L1], word_r[`PLSER_S6_L0]};
         end
         default: begin
            lane_nxt = 4'h0;
         end
      endcase
   end

   // ******************************************************
   // output stage
   // ******************************************************
   // lanes and clock leave from the same register stage so the frame
   // boundary is common to all five outputs
   always @(posedge clk or negedge irst_n) begin
      if (!irst_n) begin
         serial_lane <= 4'h0;
         serial_lane_oe <= 1'b0;
         forwarded_clock_out <= 1'b0;
         forwarded_clock_oe <= 1'b0;
         lock_valid <= 1'b0;
         pixel_ready <= 1'b0;
      end else begin
         serial_lane_oe <= locked;
         forwarded_clock_oe <= locked;
         lock_valid <= locked;
         pixel_ready <= fifo_in_ready;
         if (locked) begin
            serial_lane <= lane_nxt;
            forwarded_clock_out <= (slot_r < `PLSER_CLK_HIGH_SLOTS);
         end else begin
            serial_lane <= 4'h0;
            forwarded_clock_out <= 1'b0;
         end
      end
   end
endmodule

// File: tb/plser_chk.sv
// assertions on the pixel serializer ports
`timescale 1ns/1ps
`include "plser_map.vh"
module plser_chk (
   input wire clk,
   input wire rst_n,
   input wire pixel_clock_in,
   input wire edge_select,
   input wire shutdown_clear_n,
   input wire [`PLSER_WORD_W-1:0] parallel_pixel_bit,
   input wire pixel_ready,
   input wire [`PLSER_LANES-1:0] serial_lane,
   input wire serial_lane_oe,
   input wire forwarded_clock_out,
   input wire forwarded_clock_oe,
   input wire lock_valid
);
   // cycles since release; lock may not arrive before the settle time
   logic [8:0] up_cnt_r;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         up_cnt_r <= 9'h000;
      else if (!shutdown_clear_n)
         up_cnt_r <= 9'h000;
      else if (up_cnt_r != 9'h1FF)
         up_cnt_r <= up_cnt_r + 9'h001;
   end
   a_shut_clock_off: assert property (
      !shutdown_clear_n |-> !forwarded_clock_oe)
      else $error("clock driven in shutdown");
   a_shut_all_clear: assert property (
      !shutdown_clear_n |-> !serial_lane_oe && serial_lane == 4'h0
      && !lock_valid)
      else $error("lanes active in shutdown");
   a_unlocked_quiet: assert property (
      !lock_valid |-> !serial_lane_oe && !forwarded_clock_oe
      && serial_lane == 4'h0 && !forwarded_clock_out)
      else $error("outputs active before lock");
   a_locked_drive: assert property (
      lock_valid |-> serial_lane_oe && forwarded_clock_oe)
      else $error("outputs not driven when locked");
   a_lock_not_early: assert property (
      $rose(lock_valid) |-> up_cnt_r >= 9'h0C8)
      else $error("lock came too early");
   a_lock_in_time: assert property (
      $rose(shutdown_clear_n) |-> ##[200:300] lock_valid)
      else $error("lock came too late");
   a_clock_shape: assert property (
      @(posedge clk) disable iff (!rst_n || !shutdown_clear_n)
      $rose(forwarded_clock_out) |-> forwarded_clock_out [*5]
      ##1 !forwarded_clock_out [*3])
      else $error("forwarded clock shape wrong");
   a_ready_locked: assert property (
      lock_valid |-> pixel_ready)
      else $error("buffer full at steady state");
endmodule
bind plser_top plser_chk u_chk (
   .clk(clk), .rst_n(rst_n), .pixel_clock_in(pixel_clock_in),
   .edge_select(edge_select), .shutdown_clear_n(shutdown_clear_n),
   .parallel_pixel_bit(parallel_pixel_bit), .pixel_ready(pixel_ready),
   .serial_lane(serial_lane), .serial_lane_oe(serial_lane_oe),
   .forwarded_clock_out(forwarded_clock_out),
   .forwarded_clock_oe(forwarded_clock_oe), .lock_valid(lock_valid)
);

// File: tb/plser_rx_model.sv
// receiver model: rebuilds pixel words from lanes and forwarded clock
`timescale 1ns/1ps
module plser_rx_model #(
   parameter int PER = 8
) (
   input wire clk,
   input wire rst_n,
   input wire fclk,
   input wire fclk_oe,
   input wire [3:0] lanes,
   output logic [27:0] rx_word,
   output logic rx_stb
);
   // parallel bit of slot k, lane j at index 4*k+j
   int map [0:27] = '{1, 9, 20, 5, 0, 8, 19, 27, 7, 18, 26, 23, 6, 15,
      25, 17, 4, 14, 24, 16, 3, 13, 22, 11, 2, 12, 21, 10};
   int t;
   int tn;
   logic fclk_d;
   // slot k is sampled once, at ceil(PER*k/7) clk after the clock rises
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         t <= 99;
         fclk_d <= 1'b0;
         rx_stb <= 1'b0;
         rx_word <= 28'h0000000;
      end else begin
         fclk_d <= fclk & fclk_oe;
         tn = (fclk & fclk_oe & !fclk_d) ? 0 : t + 1;
         t <= tn;
         for (int k = 0; k < 7; k++) begin
            if (tn == (PER * k + 6) / 7) begin
               for (int j = 0; j < 4; j++) begin
                  rx_word[map[4 * k + j]] <= lanes[j];
               end
            end
         end
         rx_stb <= (tn == (PER * 6 + 6) / 7);
      end
   end
endmodule

// File: tb/pixel_lvds_serializer_28to4_tb_top.sv
// self-checking bench for the pixel serializer
`timescale 1ns/1ps
module pixel_lvds_serializer_28to4_tb_top;
   logic clk, rst_n, pclk, esel, shut_n;
   logic [27:0] word;
   logic [2:0] ph;
   logic [27:0] sent [0:1023];
   int n, failures, check_count, idx;
   wire rdy, loe, fclk, foe, lock, stb;
   wire [3:0] lanes;
   wire [27:0] rx;
   wire [27:0] pat = 28'(n) * 28'h0B5E3A7 + 28'h1234567;
   plser_top dut (.clk(clk), .rst_n(rst_n), .pixel_clock_in(pclk),
      .edge_select(esel), .shutdown_clear_n(shut_n),
      .parallel_pixel_bit(word), .pixel_ready(rdy), .serial_lane(lanes),
      .serial_lane_oe(loe), .forwarded_clock_out(fclk),
      .forwarded_clock_oe(foe), .lock_valid(lock));
   plser_rx_model rxm (.clk(clk), .rst_n(rst_n), .fclk(fclk),
      .fclk_oe(foe), .lanes(lanes), .rx_word(rx), .rx_stb(stb));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // pixel source, 8 clk period, half high; word inverted around the
   // other edge so sampling the wrong edge shows up
   always @(posedge clk) begin
      ph <= ph + 3'h1;
      pclk <= ph < 3'h4;
      if (ph == (esel ? 3'h6 : 3'h2)) begin
         word <= pat;
         sent[n] <= pat;
         n <= n + 1;
      end else if (ph == (esel ? 3'h2 : 3'h6))
         word <= ~word;
   end
   task cmp_bit(input string what, input logic exp, input logic got);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("unexpected %s: expected %b, seen %b", what, exp, got);
      end
   endtask
   task cmp_word(input string what, input logic [27:0] exp,
      input logic [27:0] got);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task conclude;
      if (failures == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task t_lock;
      int i;
      @(posedge clk);
      #1;
      cmp_bit("early lock", 1'b0, lock);
      cmp_bit("early lane drive", 1'b0, loe);
      for (i = 0; i < 400 && lock !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      cmp_bit("lock", 1'b1, lock);
      cmp_bit("clock drive", 1'b1, foe);
   endtask
   task t_stream;
      int i, j;
      idx = 0;
      for (i = -2; i < 6; i++) begin
         j = 0;
         do begin
            @(posedge clk);
            #1;
            j++;
         end while (stb !== 1'b1 && j < 20);
         cmp_bit("frame", 1'b1, stb);
         // two sync stages, one detect stage, then one frame in the buffer
         if (i == 0)
            idx = n - 3;
         if (i >= 0) begin
            cmp_word("word", sent[idx + i], rx);
            cmp_bit("buffer ready", 1'b1, rdy);
         end
      end
   endtask
   task t_shut(input logic sel);
      @(posedge clk);
      shut_n <= 1'b0;
      #12;
      cmp_bit("clock off", 1'b0, foe);
      @(posedge clk);
      #1;
      cmp_bit("lanes off", 1'b0, loe);
      cmp_word("lanes", 28'h0000000, {24'h000000, lanes});
      cmp_bit("lock cleared", 1'b0, lock);
      @(posedge clk);
      esel <= sel;
      repeat (4) @(posedge clk);
      shut_n <= 1'b1;
   endtask
   initial begin
      rst_n = 1'b0;
      shut_n = 1'b1;
      esel = 1'b1;
      pclk = 1'b0;
      word = 28'h0000000;
      ph = 3'h0;
      n = 0;
      failures = 0;
      check_count = 0;
      idx = 0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      t_lock;
      t_stream;
      t_shut(1'b0);
      t_lock;
      t_stream;
      conclude;
   end
   initial begin
      #150000;
      failures++;
      conclude;
   end
endmodule
